// *** common/spb_pkg.sv ***
// register map, field positions and reset values of the serial port buffer block
// How it works
// - With the input release bit set the data input pin is handed to port control and the shifter sees zero.
// - The transmit request follows a two-bit selector: not full, half empty or more, empty, or empty and idle.
// - The receive request follows a two-bit selector: full, half full or more, not empty, or read out empty.
// - Mode bits marked as locked take writes only while the enable bit is zero.
// - The input release bit has no effect while frame mode is on, and software leaves it zero then.
// - With audio mode on the shifter acts as if clock polarity were one, whatever the stored bit.
// - Transmit empty goes high when the last held word moves into the shift register.
// - Transmit empty goes low when software writes the data buffer location.
// - In standard mode transmit full sets on a data write and clears when the word moves to the shifter.
// - In enhanced mode transmit full is exactly core write pointer plus one equal to module read pointer.
// - In standard mode receive full sets when a received word lands and clears when software reads it.
// - In enhanced mode receive full is exactly module write pointer plus one equal to core read pointer.
package spb_pkg;
	localparam logic [7:0]  CTRL_OFS       = 8'h00;
	localparam logic [7:0]  STAT_OFS       = 8'h04;
	localparam logic [7:0]  DATA_OFS       = 8'h08;
	localparam logic [7:0]  IRQ_STAT_OFS   = 8'h0C;
	localparam logic [7:0]  IRQ_MASK_OFS   = 8'h10;
	localparam int          CTRL_RX_SEL    = 0;
	localparam int          CTRL_TX_SEL    = 2;
	localparam int          CTRL_RELEASE   = 4;
	localparam int          CTRL_ENH       = 5;
	localparam int          CTRL_CPOL      = 6;
	localparam int          CTRL_AUDIO     = 7;
	localparam int          CTRL_FRAME     = 8;
	localparam int          CTRL_ON        = 15;
	localparam logic [15:0] CTRL_RESET     = 16'h0000;
	localparam logic [15:0] CTRL_WR_MASK   = 16'h81FF;
	localparam logic [15:0] CTRL_LOCK_MASK = 16'h01E0;
	localparam int          STAT_RX_FULL   = 0;
	localparam int          STAT_TX_FULL   = 1;
	localparam int          STAT_TX_EMPTY  = 3;
	localparam int          STAT_BUSY      = 4;
	localparam int          IRQ_TX         = 0;
	localparam int          IRQ_RX         = 1;
	localparam int          IRQ_OVF        = 2;
	localparam logic [2:0]  IRQ_MASK_RESET = 3'h0;
endpackage

// *** hw/spb_sync2.sv ***
// two-stage synchroniser for pin inputs
`timescale 1ns/100ps
module spb_sync2
#(
	parameter int W = 1
)
(
	input  wire logic         ref_clk,
	input  wire logic         rst_n,
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);
	logic [W-1:0] meta_reg;

	always_ff @(posedge ref_clk)
	begin
		if (!rst_n)
		begin
			meta_reg <= '0;
			q        <= '0;
		end
		else
		begin
			meta_reg <= d;
			q        <= meta_reg;
		end
	end
endmodule

// *** hw/spb_shifter.sv ***
// serial shift engine, slave side, on the sampled link clock
`timescale 1ns/100ps
module spb_shifter
#(
	parameter int WIDTH = 8
)
(
	input  wire logic             ref_clk,
	input  wire logic             rst_n,
	input  wire logic             on,
	input  wire logic             cpol,
	input  wire logic             sck_s,
	input  wire logic             ss_n_s,
	input  wire logic             sdi_s,
	input  wire logic             tx_avail,
	input  wire logic [WIDTH-1:0] tx_word,
	output logic                  tx_load,
	output logic                  rx_done,
	output logic      [WIDTH-1:0] rx_word,
	output logic                  sdo,
	output logic                  busy
);
	localparam int CW = $clog2(WIDTH);

	logic             sck_d_reg;
	logic             act_reg;
	logic             need_reg;
	logic [CW-1:0]    cnt_reg;
	logic [WIDTH-1:0] sh_reg;

	wire             sel   = on & ~ss_n_s;
	wire             edge_w = sel & act_reg & (sck_s != sck_d_reg);
	wire             lead  = edge_w & (sck_s != cpol);
	wire             trail = edge_w & (sck_s == cpol);
	wire             start = sel & ~act_reg;
	wire             fetch = start | (trail & need_reg);
	wire [WIDTH-1:0] new_w = tx_avail ? tx_word : '0;

	// a word with nothing queued shifts out zeros
	assign tx_load = fetch & tx_avail;
	assign rx_done = lead & (cnt_reg == CW'(WIDTH - 1));
	assign rx_word = {sh_reg[WIDTH-2:0], sdi_s};

	always_ff @(posedge ref_clk)
	begin
		if (!rst_n || !sel)
		begin
			act_reg  <= 1'b0;
			need_reg <= 1'b0;
			cnt_reg  <= '0;
			busy     <= 1'b0;
		end
		else
		begin
			act_reg <= 1'b1;
			if (fetch)
				need_reg <= 1'b0;
			else if (rx_done)
				need_reg <= 1'b1;
			if (lead)
				cnt_reg <= rx_done ? '0 : cnt_reg + 1'b1;
			if (tx_load)
				busy <= 1'b1;
			else if (rx_done)
				busy <= 1'b0;
		end
	end

	always_ff @(posedge ref_clk)
	begin
		if (!rst_n)
		begin
			sck_d_reg <= 1'b0;
			sh_reg    <= '0;
			sdo       <= 1'b0;
		end
		else
		begin
			sck_d_reg <= sck_s;
			if (fetch)
			begin
				sh_reg <= new_w;
				sdo    <= new_w[WIDTH-1];
			end
			else if (lead)
				sh_reg <= rx_word;
			else if (trail)
				sdo <= sh_reg[WIDTH-1];
		end
	end
endmodule

// *** hw/spb_serial_port.sv ***
// serial port core: apb registers, buffers, status flags and interrupts
`timescale 1ns/100ps
module spb_serial_port
	import spb_pkg::*;
#(
	parameter int DEPTH = 4,
	parameter int WIDTH = 8
)
(
	input  wire logic        ref_clk,
	input  wire logic        rst_n,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        sck,
	input  wire logic        ss_n,
	input  wire logic        sdi,
	output logic             sdo,
	output logic             sdo_oe,
	output logic             sdi_release,
	output logic             tx_req,
	output logic             rx_req,
	output logic             irq
);
	localparam int PW = $clog2(DEPTH);

	////////////////////////////////////////////////////////////
	// state

	logic [15:0]      ctrl_reg;
	logic [2:0]       ists_reg;
	logic [2:0]       imask_reg;
	logic [WIDTH-1:0] tx_mem [DEPTH];
	logic [WIDTH-1:0] rx_mem [DEPTH];
	logic [PW-1:0]    cwp_reg;
	logic [PW-1:0]    srp_reg;
	logic [PW-1:0]    swp_reg;
	logic [PW-1:0]    crp_reg;
	logic [2:0]       pin_s;
	logic             tx_load;
	logic             rx_done;
	logic [WIDTH-1:0] rx_word;
	logic             busy;
	logic [31:0]      stat_w;

	////////////////////////////////////////////////////////////
	// decode and flags

	wire        on          = ctrl_reg[CTRL_ON];
	wire        enh         = ctrl_reg[CTRL_ENH];
	wire        frm         = ctrl_reg[CTRL_FRAME];
	wire [1:0]  tx_sel      = ctrl_reg[CTRL_TX_SEL +: 2];
	wire [1:0]  rx_sel      = ctrl_reg[CTRL_RX_SEL +: 2];
	wire        eff_cpol    = ctrl_reg[CTRL_AUDIO] | ctrl_reg[CTRL_CPOL];
	wire        release_pin = ctrl_reg[CTRL_RELEASE] & ~frm;
	wire        sdi_in      = pin_s[2] & ~release_pin;

	wire        acc       = psel & penable & pready;
	wire        sel_ctrl  = paddr == CTRL_OFS;
	wire        sel_stat  = paddr == STAT_OFS;
	wire        sel_data  = paddr == DATA_OFS;
	wire        sel_ists  = paddr == IRQ_STAT_OFS;
	wire        sel_imask = paddr == IRQ_MASK_OFS;
	wire        hit       = sel_ctrl | sel_stat | sel_data | sel_ists | sel_imask;
	wire        wr_ctrl   = acc & pwrite & sel_ctrl;
	wire        wr_data   = acc & pwrite & sel_data;
	wire        rd_data   = acc & ~pwrite & sel_data;
	wire        wr_ists   = acc & pwrite & sel_ists;
	wire        wr_imask  = acc & pwrite & sel_imask;
	wire        ready_nxt = psel & penable & ~pready;

	// locked bits keep their value while enabled
	wire [15:0] ctrl_wr   = pwdata[15:0] & CTRL_WR_MASK;
	wire [15:0] ctrl_next = on ? ((ctrl_reg & CTRL_LOCK_MASK) | (ctrl_wr & ~CTRL_LOCK_MASK)) : ctrl_wr;

	// standard mode holds one word, enhanced one less than the depth
	wire [PW-1:0] cap      = enh ? PW'(DEPTH - 1) : PW'(1);
	wire [PW-1:0] half     = cap >> 1;
	wire [PW-1:0] tx_cnt   = cwp_reg - srp_reg;
	wire [PW-1:0] rx_cnt   = swp_reg - crp_reg;
	wire          tx_empty = cwp_reg == srp_reg;
	wire          tx_full  = enh ? (PW'(cwp_reg + 1'b1) == srp_reg) : (cwp_reg != srp_reg);
	wire          rx_full  = enh ? (PW'(swp_reg + 1'b1) == crp_reg) : (swp_reg != crp_reg);
	wire          tx_push  = wr_data & on & ~tx_full;
	wire          rx_pop   = rd_data & (rx_cnt != '0);
	wire          rx_push  = rx_done & ~rx_full;
	wire          rx_ovf   = rx_done & rx_full;

	wire tx_cond = on & (tx_sel == 2'h3 ? ~tx_full :
		tx_sel == 2'h2 ? (tx_cnt <= half) :
		tx_sel == 2'h1 ? tx_empty : (tx_empty & ~busy));
	wire rx_cond = on & (rx_sel == 2'h3 ? rx_full :
		rx_sel == 2'h2 ? (rx_cnt >= PW'(cap - half)) :
		rx_sel == 2'h1 ? (rx_cnt != '0) : (rx_cnt == '0));

	// set wins over a clear in the same cycle
	wire [2:0] ev        = {rx_ovf, rx_cond & ~rx_req, tx_cond & ~tx_req};
	wire [2:0] ists_next = (ists_reg & ~(wr_ists ? pwdata[2:0] : 3'h0)) | ev;

	always_comb
	begin
		stat_w                = 32'h0000_0000;
		stat_w[STAT_RX_FULL]  = rx_full;
		stat_w[STAT_TX_FULL]  = tx_full;
		stat_w[STAT_TX_EMPTY] = tx_empty;
		stat_w[STAT_BUSY]     = busy;
	end

	wire [31:0] rd_mux = sel_ctrl ? {16'h0000, ctrl_reg} :
		sel_stat ? stat_w :
		sel_data ? {{(32 - WIDTH){1'b0}}, rx_mem[crp_reg]} :
		sel_ists ? {29'h0, ists_reg} :
		sel_imask ? {29'h0, imask_reg} : 32'h0000_0000;

	////////////////////////////////////////////////////////////
	// submodules

	spb_sync2 #(.W(3)) u_sync
	(
		.ref_clk (ref_clk),
		.rst_n   (rst_n),
		.d       ({sdi, ss_n, sck}),
		.q       (pin_s)
	);

	spb_shifter #(.WIDTH(WIDTH)) u_shift
	(
		.ref_clk  (ref_clk),
		.rst_n    (rst_n),
		.on       (on),
		.cpol     (eff_cpol),
		.sck_s    (pin_s[0]),
		.ss_n_s   (pin_s[1]),
		.sdi_s    (sdi_in),
		.tx_avail (~tx_empty),
		.tx_word  (tx_mem[srp_reg]),
		.tx_load  (tx_load),
		.rx_done  (rx_done),
		.rx_word  (rx_word),
		.sdo      (sdo),
		.busy     (busy)
	);

	////////////////////////////////////////////////////////////
	// registers

	always_ff @(posedge ref_clk)
	begin
		if (!rst_n)
		begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h0000_0000;
		end
		else
		begin
			pready  <= ready_nxt;
			pslverr <= ready_nxt & ~hit;
			prdata  <= (ready_nxt & ~pwrite) ? rd_mux : 32'h0000_0000;
		end
	end

	always_ff @(posedge ref_clk)
	begin
		if (!rst_n)
		begin
			ctrl_reg  <= CTRL_RESET;
			imask_reg <= IRQ_MASK_RESET;
			ists_reg  <= 3'h0;
		end
		else
		begin
			if (wr_ctrl)
				ctrl_reg <= ctrl_next;
			if (wr_imask)
				imask_reg <= pwdata[2:0];
			ists_reg <= ists_next;
		end
	end

	// clearing the enable flushes both buffers
	always_ff @(posedge ref_clk)
	begin
		if (!rst_n || !on)
		begin
			cwp_reg <= '0;
			srp_reg <= '0;
			swp_reg <= '0;
			crp_reg <= '0;
		end
		else
		begin
			if (tx_push)
				cwp_reg <= cwp_reg + 1'b1;
			if (tx_load)
				srp_reg <= srp_reg + 1'b1;
			if (rx_push)
				swp_reg <= swp_reg + 1'b1;
			if (rx_pop)
				crp_reg <= crp_reg + 1'b1;
		end
	end

	always_ff @(posedge ref_clk)
	begin
		if (tx_push)
			tx_mem[cwp_reg] <= pwdata[WIDTH-1:0];
		if (rx_push)
			rx_mem[swp_reg] <= rx_word;
	end

	always_ff @(posedge ref_clk)
	begin
		if (!rst_n)
		begin
			tx_req      <= 1'b0;
			rx_req      <= 1'b0;
			irq         <= 1'b0;
			sdi_release <= 1'b0;
			sdo_oe      <= 1'b0;
		end
		else
		begin
			tx_req      <= tx_cond;
			rx_req      <= rx_cond;
			irq         <= |(ists_reg & imask_reg);
			sdi_release <= release_pin;
			sdo_oe      <= on & ~pin_s[1];
		end
	end

	////////////////////////////////////////////////////////////
	// checks

	a_pin_release: assert property (
		@(posedge ref_clk) disable iff (!rst_n)
		(ctrl_reg[CTRL_RELEASE] && !frm) |=> sdi_release)
		else $error("input pin not released");

	a_tx_select: assert property (
		@(posedge ref_clk) disable iff (!rst_n)
		(on && tx_sel == 2'h0 && busy) |=> !tx_req)
		else $error("tx request while word still shifting");

	a_rx_select: assert property (
		@(posedge ref_clk) disable iff (!rst_n)
		(on && rx_sel == 2'h3 && rx_full) |=> rx_req)
		else $error("rx request missing on full buffer");

	a_ctrl_lock: assert property (
		@(posedge ref_clk) disable iff (!rst_n)
		(on && wr_ctrl) |=> $stable(ctrl_reg & CTRL_LOCK_MASK))
		else $error("locked bit changed while enabled");

	a_frame_pin: assert property (
		@(posedge ref_clk) disable iff (!rst_n)
		frm |=> !sdi_release)
		else $error("release active in frame mode");

	// watches the shifter, not the wire: a word must end on a falling link clock
	a_audio_pol: assert property (
		@(posedge ref_clk) disable iff (!rst_n)
		(on && ctrl_reg[CTRL_AUDIO] && rx_done) |-> !pin_s[0])
		else $error("audio mode word ended on a rising clock");

	a_empty_set: assert property (
		@(posedge ref_clk) disable iff (!rst_n)
		(on && !enh && tx_load && !tx_push) |=> tx_empty)
		else $error("tx empty not set on load");

	a_empty_clear: assert property (
		@(posedge ref_clk) disable iff (!rst_n)
		tx_push |=> !tx_empty)
		else $error("tx empty not cleared on write");

	a_full_std: assert property (
		@(posedge ref_clk) disable iff (!rst_n)
		(on && !enh && tx_push) |=> tx_full)
		else $error("standard tx full not set on write");

	a_full_clear: assert property (
		@(posedge ref_clk) disable iff (!rst_n)
		(on && !enh && tx_load) |=> !tx_full)
		else $error("standard tx full not cleared on load");

	a_full_enh: assert property (
		@(posedge ref_clk) disable iff (!rst_n)
		(enh && tx_push && !tx_load && tx_cnt == PW'(DEPTH - 2)) |=> tx_full)
		else $error("enhanced tx full missing");

	a_rx_std: assert property (
		@(posedge ref_clk) disable iff (!rst_n)
		(on && !enh && rx_pop && !rx_push) |=> !rx_full)
		else $error("standard rx full not cleared");

	a_rx_set: assert property (
		@(posedge ref_clk) disable iff (!rst_n)
		(on && !enh && rx_push) |=> rx_full)
		else $error("standard rx full not set on receive");

	a_rx_enh: assert property (
		@(posedge ref_clk) disable iff (!rst_n)
		(enh && rx_full) |-> rx_cnt == PW'(DEPTH - 1))
		else $error("enhanced rx full wrong count");

	a_tx_level: assert property (
		@(posedge ref_clk) disable iff (!rst_n)
		tx_cond [*2] |-> tx_req)
		else $error("tx request dropped while condition holds");

	a_irq_out: assert property (
		@(posedge ref_clk) disable iff (!rst_n)
		(|(ists_reg & imask_reg)) |=> irq)
		else $error("irq not raised");

	a_rx_empty_sel: assert property (
		@(posedge ref_clk) disable iff (!rst_n)
		(on && rx_sel == 2'h0 && rx_full) |=> !rx_req)
		else $error("rx request on empty select with data held");

	a_tx_notfull: assert property (
		@(posedge ref_clk) disable iff (!rst_n)
		(on && tx_sel == 2'h3 && tx_full) |=> !tx_req)
		else $error("tx request on not full select while full");

	a_rx_level: assert property (
		@(posedge ref_clk) disable iff (!rst_n)
		rx_cond [*2] |-> rx_req)
		else $error("rx request dropped while condition holds");

	a_pready_pulse: assert property (
		@(posedge ref_clk) disable iff (!rst_n)
		pready |=> !pready)
		else $error("ready held longer than one cycle");

	a_slverr_ready: assert property (
		@(posedge ref_clk) disable iff (!rst_n)
		pslverr |-> pready)
		else $error("slave error without ready");

	a_oe_off: assert property (
		@(posedge ref_clk) disable iff (!rst_n)
		!on |=> !sdo_oe)
		else $error("data output driven while disabled");
endmodule

// *** bench/spb_link_master.sv ***
// link master model: drives serial clock, select and data pins
`timescale 1ns/100ps
////////////////////////////////////////
module spb_link_master
(
	input  wire logic sdo,
	output logic      sck,
	output logic      ss_n,
	output logic      sdi
);
	logic pol;
	initial
	begin
		pol = 1'b0;
		sck = 1'b0;
		ss_n = 1'b1;
		sdi = 1'b0;
	end
	////////////////////////////////////////
	// clock stands still between frames; n words back to back, msb first
	task automatic xfer(input int n, input logic [31:0] tx, output logic [31:0] rx);
		int i;
		rx = 32'h0;
		sck = pol;
		#100;
		ss_n = 1'b0;
		#200;
		for (i = 8*n-1; i >= 0; i--)
		begin
			sdi = tx[i];
			#62.5;
			sck = ~pol;
			rx[i] = sdo;
			#62.5;
			sck = pol;
		end
		#200;
		ss_n = 1'b1;
		// no pull on the line, so show the inverse of the last bit
		sdi = ~sdi;
	endtask
	// select alone, no clock edges: lets the bench see the output enable
	task automatic select(input logic v);
		ss_n <= v;
	endtask
endmodule

// *** bench/testbench.sv ***
// self-checking bench for the serial port buffer block
`timescale 1ns/100ps
////////////////////////////////////////
module testbench;
	import spb_pkg::*;
	localparam logic [31:0] ON  = 32'h1 << CTRL_ON;
	localparam logic [31:0] ENH = 32'h1 << CTRL_ENH;
	localparam logic [31:0] AUD = 32'h1 << CTRL_AUDIO;
	localparam logic [31:0] FRM = 32'h1 << CTRL_FRAME;
	localparam logic [31:0] REL = 32'h1 << CTRL_RELEASE;
	localparam logic [31:0] RXW = 32'h81422418;
	logic        ref_clk, rst_n, psel, penable, pwrite, err;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, rd, got;
	logic        pready, pslverr, sck, ss_n, sdi, sdo, sdo_oe;
	logic        sdi_release, tx_req, rx_req, irq;
	int          mismatches, tests_run, c, s;

	spb_serial_port #(.DEPTH(4), .WIDTH(8)) DUT
	(
		.ref_clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
		.pready, .pslverr, .sck, .ss_n, .sdi, .sdo, .sdo_oe, .sdi_release,
		.tx_req, .rx_req, .irq
	);
	spb_link_master link (.sdo, .sck, .ss_n, .sdi);

	initial
	begin
		ref_clk = 1'b0;
		forever #2.5 ref_clk = ~ref_clk;
	end
	////////////////////////////////////////
	task automatic stop_test();
		if (mismatches == 0 && tests_run > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic chk_word(input logic [31:0] g, input logic [31:0] e);
		tests_run++;
		if (g !== e)
		begin
			mismatches++;
			$display("[ERR] %0t got %h exp %h", $time, g, e);
		end
	endtask
	task automatic chk_bit(input logic g, input logic e);
		chk_word({31'h0, g}, {31'h0, e});
	endtask
	// lags of up to two cycles settle before the caller looks
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge ref_clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge ref_clk);
		penable <= 1'b1;
		n = 0;
		do
		begin
			@(posedge ref_clk);
			n++;
		end
		while (pready !== 1'b1 && n < 50);
		if (n >= 50)
		begin
			mismatches++;
			stop_test();
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		repeat (3) @(posedge ref_clk);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask
	task automatic rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		chk_word(rd & m, e);
	endtask
	////////////////////////////////////////
	initial
	begin
		rst_n = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		mismatches = 0;
		tests_run = 0;
		repeat (2) @(posedge ref_clk);
		rst_n <= 1'b1;
		chk_bit(irq, 1'b0);
		rdc(CTRL_OFS, 32'hFFFF, {16'h0, CTRL_RESET});
		rdc(IRQ_MASK_OFS, 32'h7, {29'h0, IRQ_MASK_RESET});
		rdc(8'h20, 32'hFFFFFFFF, 32'h0);
		chk_bit(err, 1'b1);
		wr(CTRL_OFS, REL);
		chk_bit(sdi_release, 1'b1);
		wr(CTRL_OFS, REL | FRM);
		chk_bit(sdi_release, 1'b0);
		wr(CTRL_OFS, 32'h0);
		chk_bit(sdi_release, 1'b0);
		wr(CTRL_OFS, ON);
		wr(CTRL_OFS, ON | ENH);
		rdc(CTRL_OFS, 32'hFFFF, ON);
		wr(CTRL_OFS, 32'h0);
		@(posedge ref_clk);
		// standard mode, one word each way
		wr(CTRL_OFS, ON | 32'h4);
		rdc(STAT_OFS, 32'hB, 32'h8);
		chk_bit(tx_req, 1'b1);
		wr(DATA_OFS, 32'hA5);
		rdc(STAT_OFS, 32'hB, 32'h2);
		chk_bit(tx_req, 1'b0);
		link.xfer(1, 32'h3C, got);
		chk_word(got, 32'hA5);
		rdc(STAT_OFS, 32'hB, 32'h9);
		rdc(DATA_OFS, 32'hFF, 32'h3C);
		rdc(STAT_OFS, 32'h1, 32'h0);
		// tx empty here, so a bare select pops nothing
		link.select(1'b0);
		repeat (5) @(posedge ref_clk);
		chk_bit(sdo_oe, 1'b1);
		link.select(1'b1);
		repeat (5) @(posedge ref_clk);
		chk_bit(sdo_oe, 1'b0);
		wr(CTRL_OFS, 32'h0);
		@(posedge ref_clk);
		// audio mode with stored polarity zero
		wr(CTRL_OFS, ON | AUD);
		wr(DATA_OFS, 32'h96);
		link.pol = 1'b1;
		link.xfer(1, 32'h5A, got);
		chk_word(got, 32'h96);
		rdc(DATA_OFS, 32'hFF, 32'h5A);
		link.pol = 1'b0;
		wr(CTRL_OFS, 32'h0);
		@(posedge ref_clk);
		// enhanced mode: fill tx past full, every selector at each count
		wr(CTRL_OFS, ON | ENH);
		for (c = 0; c < 4; c++)
		begin
			for (s = 0; s < 4; s++)
			begin
				wr(CTRL_OFS, ON | ENH | (s << CTRL_TX_SEL));
				chk_bit(tx_req, s == 3 ? c < 3 : s == 2 ? c < 2 : c == 0);
			end
			rdc(STAT_OFS, 32'h2, {30'h0, c == 3, 1'b0});
			wr(DATA_OFS, 32'h11 * (c + 1));
		end
		wr(IRQ_MASK_OFS, 32'h4);
		chk_bit(irq, 1'b0);
		link.xfer(4, RXW, got);
		chk_word(got, 32'h11223300);
		chk_bit(irq, 1'b1);
		rdc(IRQ_STAT_OFS, 32'h4, 32'h4);
		for (c = 3; c >= 0; c--)
		begin
			for (s = 0; s < 4; s++)
			begin
				wr(CTRL_OFS, ON | ENH | (s << CTRL_RX_SEL));
				chk_bit(rx_req, s == 3 ? c == 3 : s == 2 ? c >= 2 : s == 1 ? c >= 1 : c == 0);
			end
			rdc(STAT_OFS, 32'h1, {31'h0, c == 3});
			if (c > 0)
				rdc(DATA_OFS, 32'hFF, (RXW >> (8 * c)) & 32'hFF);
		end
		wr(IRQ_STAT_OFS, 32'h4);
		rdc(IRQ_STAT_OFS, 32'h4, 32'h0);
		chk_bit(irq, 1'b0);
		stop_test();
	end
endmodule
